// ==== core/hbridge_drive_protect_chopper.sv ====
// Top level of the full-bridge drive, protection and chopper logic.
// Assumes comparator and protection indications arrive as raw levels.
`timescale 1ns/1ps
module hbridge_drive_protect_chopper #(
   parameter int OSC_DIV = hbridge_pkg::OSC_DIV_DEFAULT,
   parameter int TRIP_W  = 10
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // Host control
   input  wire logic                 dir_ctrl_a,
   input  wire logic                 dir_ctrl_b,
   input  wire logic                 speed_in,
   input  wire logic [1:0]           trip_delay_set,
   // Analog indications
   input  wire logic [3:0]           overcurrent_trip,
   input  wire logic                 thermal_trip,
   input  wire logic                 overvoltage_trip,
   input  wire logic                 undervoltage_lockout,
   input  wire logic                 sense_voltage,
   input  wire logic                 sense_ground,
   // Bridge gates
   output hbridge_pkg::gate_t        bridge_leg_a,
   output hbridge_pkg::gate_t        bridge_leg_b,
   // Alert open drain
   output logic                      alert_o,
   output logic                      alert_oe,
   // Status
   output hbridge_pkg::fault_t       fault_r,
   output logic                      discharge_r
);

   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   localparam int NIN = 14;
   logic [NIN-1:0] raw;
   logic [NIN-1:0] syn;
   logic           a_s, b_s, spd_s, th_s, ov_s, uv_s, sv_s, sg_s;
   logic [3:0]     oc_s;
   logic [1:0]     sel_s;

   assign raw = {dir_ctrl_a, dir_ctrl_b, speed_in, thermal_trip, overvoltage_trip,
                 undervoltage_lockout, sense_voltage, sense_ground,
                 overcurrent_trip, trip_delay_set};

   hbridge_sync #(.WIDTH(NIN)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     (raw),
      .q     (syn)
   );

   assign {a_s, b_s, spd_s, th_s, ov_s, uv_s, sv_s, sg_s, oc_s, sel_s} = syn;

   logic clear_req;
   assign clear_req = !a_s && !b_s;

   // ----------------------------------------
   // Overcurrent qualification
   // ----------------------------------------
   function automatic logic [TRIP_W-1:0] trip_limit(input logic [1:0] sel);
      case (sel)
         hbridge_pkg::TRIP_SEL_SHORT: trip_limit = TRIP_W'(hbridge_pkg::TRIP_1_6_CYC);
         hbridge_pkg::TRIP_SEL_MID:   trip_limit = TRIP_W'(hbridge_pkg::TRIP_2_8_CYC);
         default:                     trip_limit = TRIP_W'(hbridge_pkg::TRIP_12_4_CYC);
      endcase
   endfunction

   logic [TRIP_W-1:0] oc_cnt_r [4];
   logic [3:0]        oc_qual;

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_oc
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
               oc_cnt_r[g] <= '0;
            else if (!oc_s[g])
               oc_cnt_r[g] <= '0;
            else if (oc_cnt_r[g] < trip_limit(sel_s))
               oc_cnt_r[g] <= oc_cnt_r[g] + TRIP_W'(1);
         end
         assign oc_qual[g] = oc_s[g] && (oc_cnt_r[g] >= trip_limit(sel_s));
      end
   endgenerate

   // ----------------------------------------
   // Fault latching
   // ----------------------------------------
   // A trip present during the clear code wins, so a live fault is never hidden.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         fault_r <= '0;
      else
      begin
         fault_r.thermal_trip         <= th_s || (fault_r.thermal_trip && !clear_req);
         fault_r.overcurrent_trip     <= (|oc_qual)
                                         || (fault_r.overcurrent_trip && !clear_req);
         fault_r.sense_trip           <= sg_s || (fault_r.sense_trip && !clear_req);
         fault_r.overvoltage_trip     <= ov_s;
         fault_r.undervoltage_lockout <= uv_s;
      end
   end

   logic any_fault;
   assign any_fault = |fault_r;

   // ----------------------------------------
   // Alert output
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         alert_o  <= 1'b0;
         alert_oe <= 1'b1;
      end
      else
      begin
         alert_o  <= 1'b0;
         alert_oe <= !any_fault;
      end
   end

   // ----------------------------------------
   // Chopper oscillator
   // ----------------------------------------
   logic [15:0] osc_cnt_r;
   logic        osc_tick;
   assign osc_tick = (osc_cnt_r == 16'(OSC_DIV - 1));

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         osc_cnt_r <= 16'h0000;
      else if (osc_tick)
         osc_cnt_r <= 16'h0000;
      else
         osc_cnt_r <= osc_cnt_r + 16'h0001;
   end

   // ----------------------------------------
   // Chopper state machine
   // ----------------------------------------
   typedef enum logic [1:0] {
      CH_CHARGE,
      CH_DIS_FIRST,
      CH_DIS_SECOND,
      CH_CHARGE_HOLD
   } chop_t;

   chop_t      chop_r;
   logic [2:0] tick_r;
   logic       ticks_done;
   assign ticks_done = osc_tick && (tick_r == 3'(hbridge_pkg::CHOP_TICKS - 1));

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         chop_r <= CH_CHARGE;
         tick_r <= 3'h0;
      end
      else
      begin
         if (chop_r == CH_CHARGE || chop_r == CH_CHARGE_HOLD || ticks_done)
            tick_r <= 3'h0;
         else if (osc_tick)
            tick_r <= tick_r + 3'h1;
         case (chop_r)
            CH_CHARGE:
               if (sv_s)
                  chop_r <= CH_DIS_FIRST;
            CH_DIS_FIRST:
               if (ticks_done)
                  chop_r <= sv_s ? CH_DIS_SECOND : CH_CHARGE;
            CH_DIS_SECOND:
               if (ticks_done)
                  chop_r <= CH_CHARGE_HOLD;
            CH_CHARGE_HOLD:
               if (!sv_s)
                  chop_r <= CH_CHARGE;
            default:
               chop_r <= CH_CHARGE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         discharge_r <= 1'b0;
      else
         discharge_r <= (chop_r == CH_DIS_FIRST) || (chop_r == CH_DIS_SECOND);
   end

   // ----------------------------------------
   // Mode decoding
   // ----------------------------------------
   hbridge_pkg::leg_t req_a, req_b;
   logic              chop_brake;
   assign chop_brake = (chop_r == CH_DIS_FIRST) || (chop_r == CH_DIS_SECOND);

   always_comb
   begin
      req_a = hbridge_pkg::LEG_OFF;
      req_b = hbridge_pkg::LEG_OFF;
      if (any_fault)
      begin
         req_a = hbridge_pkg::LEG_OFF;
         req_b = hbridge_pkg::LEG_OFF;
      end
      else
      begin
         case ({a_s, b_s})
            2'h3:
            begin
               req_a = hbridge_pkg::LEG_LOW;
               req_b = hbridge_pkg::LEG_LOW;
            end
            2'h2, 2'h1:
            begin
               // Pulsing the direction pins lands here or in brake/stop directly
               if (!spd_s || chop_brake)
               begin
                  req_a = hbridge_pkg::LEG_LOW;
                  req_b = hbridge_pkg::LEG_LOW;
               end
               else
               begin
                  req_a = a_s ? hbridge_pkg::LEG_HIGH : hbridge_pkg::LEG_LOW;
                  req_b = b_s ? hbridge_pkg::LEG_HIGH : hbridge_pkg::LEG_LOW;
               end
            end
            default:
            begin
               req_a = hbridge_pkg::LEG_OFF;
               req_b = hbridge_pkg::LEG_OFF;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Legs with dead time
   // ----------------------------------------
   hbridge_leg u_leg_a (
      .clk    (clk),
      .reset  (reset),
      .req    (req_a),
      .gate_r (bridge_leg_a)
   );

   hbridge_leg u_leg_b (
      .clk    (clk),
      .reset  (reset),
      .req    (req_b),
      .gate_r (bridge_leg_b)
   );

endmodule

// ==== core/hbridge_leg.sv ====
// One bridge leg: turns a requested level into gate drives with dead time.
// Both gates are off for the dead time on any change between levels.
`timescale 1ns/1ps
module hbridge_leg #(
   parameter int DEAD = hbridge_pkg::DEAD_CYCLES
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // Request
   input  hbridge_pkg::leg_t       req,
   // Gates
   output hbridge_pkg::gate_t      gate_r
);
   hbridge_pkg::leg_t cur_r;
   logic [7:0]        dead_r;

   // ----------------------------------------
   // Dead time sequencing
   // ----------------------------------------
   // Off is reached at once for safety; only turning a transistor on waits.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cur_r  <= hbridge_pkg::LEG_OFF;
         dead_r <= 8'h00;
         gate_r <= '0;
      end
      else if (req != cur_r)
      begin
         cur_r  <= req;
         dead_r <= 8'(DEAD);
         gate_r <= '0;
      end
      else if (dead_r != 8'h00)
      begin
         dead_r <= dead_r - 8'h01;
         gate_r <= '0;
      end
      else
      begin
         gate_r.hi <= (cur_r == hbridge_pkg::LEG_HIGH);
         gate_r.lo <= (cur_r == hbridge_pkg::LEG_LOW);
      end
   end
endmodule

// ==== core/hbridge_pkg.sv ====
// Constants and carrier types for the full-bridge drive logic.
// Assumes a single 50 MHz clock and asynchronous active-high reset.
// What this block does
// - Decode direction pins to brake, stop, drive
// - Low speed input forces short brake in the drive codes
// - Alert released while any protection active
// - Both direction inputs low clear latched faults
// - Undervoltage forces high impedance, self recovers
// - Overvoltage forces high impedance, self recovers
// - Thermal trip latches high impedance
// - Qualified overcurrent on any transistor latches
// - Overcurrent qualification time is configurable counter
// - Dead time on every leg transition
// - Speed pulses accepted on direction pins
// - Sense ground trip latches like overcurrent
// - Sense threshold reached enters discharge brake
// - Four oscillator ticks then charge
// - Still above threshold: one more discharge
// - Target reached in charge: full discharge
// - Short brake wins over driving
// - Alert is open drain, low when normal
package hbridge_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ          = 50;
   localparam int DEAD_TIME_NS     = 200;
   localparam int DEAD_CYCLES      = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int TRIP_1_6_NS      = 1600;
   localparam int TRIP_2_8_NS      = 2800;
   localparam int TRIP_12_4_NS     = 12400;
   localparam int TRIP_1_6_CYC     = (TRIP_1_6_NS * CLK_MHZ + 999) / 1000;
   localparam int TRIP_2_8_CYC     = (TRIP_2_8_NS * CLK_MHZ + 999) / 1000;
   localparam int TRIP_12_4_CYC    = (TRIP_12_4_NS * CLK_MHZ + 999) / 1000;
   localparam int CHOP_TICKS       = 4;
   localparam int OSC_DIV_DEFAULT  = 500;
   localparam int SYNC_STAGES      = 2;

   // ----------------------------------------
   // Trip delay selection codes
   // ----------------------------------------
   localparam logic [1:0] TRIP_SEL_SHORT = 2'h0;
   localparam logic [1:0] TRIP_SEL_MID   = 2'h1;
   localparam logic [1:0] TRIP_SEL_LONG  = 2'h2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      LEG_OFF,
      LEG_HIGH,
      LEG_LOW
   } leg_t;

   typedef struct packed {
      logic hi;
      logic lo;
   } gate_t;

   typedef struct packed {
      logic thermal_trip;
      logic overcurrent_trip;
      logic sense_trip;
      logic overvoltage_trip;
      logic undervoltage_lockout;
   } fault_t;

endpackage

// ==== core/hbridge_sync.sv ====
// Multi-stage synchroniser for a bundle of asynchronous levels.
// Only the final stage is visible outside.
`timescale 1ns/1ps
module hbridge_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage_r [hbridge_pkg::SYNC_STAGES];

   // ----------------------------------------
   // Chain
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < hbridge_pkg::SYNC_STAGES; i++)
            stage_r[i] <= '0;
      end
      else
      begin
         stage_r[0] <= d;
         for (int i = 1; i < hbridge_pkg::SYNC_STAGES; i++)
            stage_r[i] <= stage_r[i-1];
      end
   end

   assign q = stage_r[hbridge_pkg::SYNC_STAGES-1];
endmodule

// ==== tb/hbridge_drive_protect_chopper_asserts.sv ====
// Port checker for the full-bridge drive top level.
// Bound into every instance of the top module.
`timescale 1ns/1ps
module hbridge_drive_protect_chopper_asserts #(
   parameter int OSC_DIV = 4
) (
   // Clock and reset
   input wire logic                clk,
   input wire logic                reset,
   // Host pins and lockouts
   input wire logic                dir_ctrl_a,
   input wire logic                dir_ctrl_b,
   input wire logic                overvoltage_trip,
   input wire logic                undervoltage_lockout,
   // Outputs
   input wire hbridge_pkg::gate_t  bridge_leg_a,
   input wire hbridge_pkg::gate_t  bridge_leg_b,
   input wire logic                alert_o,
   input wire logic                alert_oe,
   input wire hbridge_pkg::fault_t fault_r,
   input wire logic                discharge_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   int unsigned off_a;
   int unsigned off_b;
   int unsigned dis_n;
   logic [2:0]  lat;
   assign lat = {fault_r.thermal_trip, fault_r.overcurrent_trip, fault_r.sense_trip};

   // Run lengths of gates-off and of discharge
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         off_a <= 0;
         off_b <= 0;
         dis_n <= 0;
      end
      else
      begin
         off_a <= (bridge_leg_a == 2'h0) ? off_a + 1 : 0;
         off_b <= (bridge_leg_b == 2'h0) ? off_b + 1 : 0;
         dis_n <= discharge_r ? dis_n + 1 : 0;
      end
   end

   AST_DEAD_A: assert property (($rose(bridge_leg_a.hi) || $rose(bridge_leg_a.lo))
      |-> off_a >= hbridge_pkg::DEAD_CYCLES) else $error("leg a on without dead time");
   AST_DEAD_B: assert property (($rose(bridge_leg_b.hi) || $rose(bridge_leg_b.lo))
      |-> off_b >= hbridge_pkg::DEAD_CYCLES) else $error("leg b on without dead time");
   AST_FAULT_OFF: assert property ((|fault_r)[*3]
      |-> bridge_leg_a == 2'h0 && bridge_leg_b == 2'h0) else $error("gates on in fault");
   AST_ALERT: assert property (1 |=> alert_oe == !$past(|fault_r) && !alert_o)
      else $error("alert pin wrong");
   AST_LATCH: assert property ((|lat && (dir_ctrl_a || dir_ctrl_b))[*4]
      |=> (lat & $past(lat)) == $past(lat)) else $error("latched fault cleared");
   AST_UV: assert property ($stable(undervoltage_lockout)[*4]
      |-> fault_r.undervoltage_lockout == undervoltage_lockout) else $error("uv lock wrong");
   AST_OV: assert property ($stable(overvoltage_trip)[*4]
      |-> fault_r.overvoltage_trip == overvoltage_trip) else $error("ov lock wrong");
   AST_DISCH_LEN: assert property ($fell(discharge_r)
      |-> dis_n >= 3 * OSC_DIV && dis_n <= 8 * OSC_DIV) else $error("discharge length");
   AST_DISCH_BRAKE: assert property (discharge_r[*4]
      |-> !bridge_leg_a.hi && !bridge_leg_b.hi) else $error("drive during discharge");
   AST_STOP: assert property ((!dir_ctrl_a && !dir_ctrl_b)[*6]
      |-> bridge_leg_a == 2'h0 && bridge_leg_b == 2'h0) else $error("stop not off");
endmodule

bind hbridge_drive_protect_chopper hbridge_drive_protect_chopper_asserts #(
   .OSC_DIV(OSC_DIV)
) i_asserts (.clk, .reset, .dir_ctrl_a, .dir_ctrl_b, .overvoltage_trip,
   .undervoltage_lockout, .bridge_leg_a, .bridge_leg_b, .alert_o, .alert_oe,
   .fault_r, .discharge_r);

// ==== tb/hbridge_host.sv ====
// Host controller model: drives the direction and speed pins.
// Assumes the bench posts a command just after a rising edge.
`timescale 1ns/1ps
module hbridge_host (
   // Clock
   input  wire logic       clk,
   // Command {a, b, speed}
   input  wire logic [2:0] cmd,
   // Pins
   output logic            dir_ctrl_a,
   output logic            dir_ctrl_b,
   output logic            speed_in
);
   initial
   begin
      {dir_ctrl_a, dir_ctrl_b, speed_in} = 3'h0;
   end

   // Pulses may ride on the direction pins; both low clears a trip
   always @(posedge clk)
   begin
      {dir_ctrl_a, dir_ctrl_b, speed_in} <= cmd;
   end
endmodule

// ==== tb/test_hbridge_drive_protect_chopper.sv ====
// Self-checking bench for the full-bridge drive, protection and chopper.
// Runs the top level with a short oscillator divider behind a host model.
`timescale 1ns/1ps
module test_hbridge_drive_protect_chopper;
   localparam int DIV = 8;
   logic                clk;
   logic                reset = 1'b1;
   logic [2:0]          cmd = 3'h0;
   logic                dir_ctrl_a, dir_ctrl_b, speed_in, alert_o, alert_oe, discharge_r;
   logic [1:0]          trip_delay_set = 2'h0;
   logic [3:0]          overcurrent_trip = 4'h0;
   logic                thermal_trip = 1'b0, overvoltage_trip = 1'b0, sense_ground = 1'b0;
   logic                undervoltage_lockout = 1'b0, sense_voltage = 1'b0;
   hbridge_pkg::gate_t  bridge_leg_a, bridge_leg_b;
   hbridge_pkg::fault_t fault_r;
   int                  miscompares = 0, cmp_count = 0, ticks = 0, i, k, lim;
   // Rows: {a, b, speed, leg a, leg b}
   logic [6:0]          rows [8] = '{7'h10, 7'h59, 7'h36, 7'h75, 7'h45, 7'h65, 7'h25, 7'h00};

   hbridge_host i_hbridge_host (.clk, .cmd, .dir_ctrl_a, .dir_ctrl_b, .speed_in);
   hbridge_drive_protect_chopper #(.OSC_DIV(DIV)) i_hbridge_drive_protect_chopper (.clk,
      .reset, .dir_ctrl_a, .dir_ctrl_b, .speed_in, .trip_delay_set, .overcurrent_trip,
      .thermal_trip, .overvoltage_trip, .undervoltage_lockout, .sense_voltage, .sense_ground,
      .bridge_leg_a, .bridge_leg_b, .alert_o, .alert_oe, .fault_r, .discharge_r);

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Compares on the falling edge so the registered outputs have settled
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      @(negedge clk);
      cmp_count++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
      @(posedge clk);
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Ceiling well above the longest path through the tests
   always @(posedge clk)
   begin
      ticks++;
      if (ticks == 8000)
      begin
         miscompares++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      cyc(6);
      chk({alert_o, alert_oe, fault_r, bridge_leg_a, bridge_leg_b}, 12'h200);
      reset <= 1'b0;
      foreach (rows[i])
      begin
         cmd <= rows[i][6:4];
         cyc(20);
         chk({bridge_leg_a, bridge_leg_b}, {8'h00, rows[i][3:0]});
      end
      cmd <= 3'h5;
      cyc(20);
      for (k = 0; k < 2; k++)
      begin
         thermal_trip <= (k == 0);
         sense_ground <= (k == 1);
         cyc(4);
         thermal_trip <= 1'b0;
         sense_ground <= 1'b0;
         cyc(20);
         chk({alert_oe, fault_r, bridge_leg_a, bridge_leg_b}, k ? 12'h040 : 12'h100);
         cmd <= 3'h0;
         cyc(10);
         chk({alert_oe, fault_r, bridge_leg_a, bridge_leg_b}, 12'h200);
         cmd <= 3'h5;
         undervoltage_lockout <= (k == 0);
         overvoltage_trip <= (k == 1);
         cyc(10);
         chk({alert_oe, fault_r, bridge_leg_a, bridge_leg_b}, k ? 12'h020 : 12'h010);
         undervoltage_lockout <= 1'b0;
         overvoltage_trip <= 1'b0;
         cyc(20);
         chk({alert_oe, fault_r, bridge_leg_a, bridge_leg_b}, 12'h209);
      end
      for (k = 0; k < 4; k++)
      begin
         lim = (k == 0) ? hbridge_pkg::TRIP_1_6_CYC :
               (k == 1) ? hbridge_pkg::TRIP_2_8_CYC : hbridge_pkg::TRIP_12_4_CYC;
         trip_delay_set <= k[1:0];
         cyc(5);
         overcurrent_trip <= 4'h1 << k;
         cyc(lim - 10);
         overcurrent_trip <= 4'h0;
         cyc(10);
         chk(fault_r, 12'h000);
         overcurrent_trip <= 4'h1 << k;
         cyc(lim + 10);
         overcurrent_trip <= 4'h0;
         cyc(5);
         chk({alert_oe, fault_r, bridge_leg_a, bridge_leg_b}, 12'h080);
         cmd <= 3'h0;
         cyc(10);
         cmd <= 3'h5;
         cyc(20);
      end
      for (k = 0; k < 2; k++)
      begin
         sense_voltage <= 1'b1;
         for (i = 0; i < 10 && discharge_r !== 1'b1; i++)
            @(negedge clk);
         chk(discharge_r, 12'h001);
         cyc(16);
         chk({bridge_leg_a, bridge_leg_b}, 12'h005);
         cyc(k ? 70 : 0);
         // Two discharge rounds are over, so the drive is back although sense is high
         if (k) chk({bridge_leg_a, bridge_leg_b}, 12'h009);
         sense_voltage <= 1'b0;
         for (i = 0; i < 100 && discharge_r !== 1'b0; i++)
            @(negedge clk);
         chk(discharge_r, 12'h000);
         cyc(20);
         chk({bridge_leg_a, bridge_leg_b}, 12'h009);
      end
      wrap_up();
   end
endmodule
